// ---- serial_eeprom_board_setup_loader.sv ----
// board setup loader: avalon register file and three-wire serial eeprom engine
// Behaviour
// [RULE1] after reset fetch setup from eeprom automatically
// [RULE2] config at strap times four, base plus one
// [RULE3] station words from 20h to 22h always
// [RULE4] straps seven: station only, fixed config/base; here a commit still writes config and base to words 1Ch and 1Dh
// [RULE5] eeprom is 64 words, whole-word accesses
// [RULE6] target zero fetch updates config, base, station
// [RULE7] target zero commit writes config and base
// [RULE8] low three control bits never touch eeprom; here fetch (bit 1) and commit (bit 0) start eeprom accesses
// [RULE9] target one fetch reads pointer word to general
// [RULE10] target one commit writes general to pointer word
// [RULE11] triggers read high while access runs
// [RULE12] all other accesses stall until access completes; here reads of control stall as well
// [RULE13] enable pin low: no eeprom access, defaults
// [RULE14] straps all high give fixed base default
// [RULE15] chip select, start, opcode, address, data framing
//
// The Avalon-MM register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module serial_eeprom_board_setup_loader
    import setup_loader_pkg::*;
(
    input wire logic clk_sys, // 40 mhz system clock
    input wire logic sys_rst, // synchronous reset, active high
    input wire logic [3:0] avs_address, // word address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall
    input wire logic [2:0] board_select_straps, // setup word placement
    input wire logic eeprom_enable_pin, // low when no eeprom fitted
    output logic ee_cs, // eeprom chip select
    output logic ee_sk, // eeprom serial clock
    output logic ee_di, // data to eeprom
    input wire logic ee_do, // data from eeprom
    output logic [15:0] config_word, // configuration register
    output logic [15:0] base_word // base register
);
    import setup_loader_pkg::*;

    typedef enum {S_IDLE, S_PICK, S_SHIFT, S_GAP, S_POLL, S_DONE} state_e;

    state_e state, next_state;
    logic [2:0] control, next_control;
    logic [15:0] cfg, next_cfg, base, next_base, gp, next_gp;
    logic [15:0] station [3];
    logic [15:0] next_station [3];
    logic [5:0] pointer, next_pointer;
    logic busy, next_busy;
    logic [2:0] step, next_step; // 0..2 station, 3 cfg, 4 base
    logic writing, next_writing;
    logic wen_done, next_wen_done;
    logic [26:0] shreg, next_shreg;
    logic [5:0] bitcnt, next_bitcnt;
    logic [5:0] fbits, next_fbits;
    logic [15:0] rxd, next_rxd;
    logic [7:0] div, next_div;
    logic sk, next_sk, cs, next_cs, di, next_di;
    logic [31:0] poll, next_poll;
    logic started, next_started;
    logic [5:0] cur_addr;
    logic [15:0] cur_data;
    logic [2:0] last_step;
    logic tick;
    logic [5:0] strap_word;

    assign strap_word = {1'b0, board_select_straps, 2'b00}; // [RULE2]
    assign tick = (div == 8'(SK_HALF_CYC - 1));

    always_comb
    begin
        cur_addr = STATION_WORD0 + 6'(step);
        cur_data = gp;
        if (control[CTL_TARGET])
        begin
            cur_addr = pointer; // [RULE9] [RULE10]
        end
        else if (step == 3'h3)
        begin
            cur_addr = strap_word;
            cur_data = cfg;
        end
        else if (step == 3'h4)
        begin
            cur_addr = strap_word + 6'h01; // [RULE2]
            cur_data = base;
        end
    end

    always_comb
    begin
        last_step = 3'h4;
        if (control[CTL_TARGET] || (board_select_straps == STRAP_ALL_HIGH && !writing))
        begin
            last_step = control[CTL_TARGET] ? step : 3'h2; // [RULE4]
        end
    end

    always_comb
    begin
        next_state = state;
        next_control = control;
        next_cfg = cfg;
        next_base = base;
        next_gp = gp;
        next_station = station;
        next_pointer = pointer;
        next_busy = busy;
        next_step = step;
        next_writing = writing;
        next_wen_done = wen_done;
        next_shreg = shreg;
        next_bitcnt = bitcnt;
        next_fbits = fbits;
        next_rxd = rxd;
        next_div = tick ? 8'h00 : div + 8'h01;
        next_sk = sk;
        next_cs = cs;
        next_di = di;
        next_poll = poll;
        next_started = 1'b1;
        avs_waitrequest = busy && (avs_read || avs_write); // [RULE12]
        avs_readdata = 32'h0000_0000;
        unique case (avs_address)
            ADDR_CONTROL: avs_readdata = {29'h0, control[CTL_TARGET], busy, busy}; // [RULE11]
            ADDR_CONFIG: avs_readdata = {16'h0, cfg};
            ADDR_BASE: avs_readdata = {16'h0, base};
            ADDR_STATION0: avs_readdata = {16'h0, station[0]};
            ADDR_STATION1: avs_readdata = {16'h0, station[1]};
            ADDR_STATION2: avs_readdata = {16'h0, station[2]};
            ADDR_POINTER: avs_readdata = {26'h0, pointer};
            ADDR_GENERAL: avs_readdata = {16'h0, gp};
            default: avs_readdata = 32'h0000_0000;
        endcase
        if (avs_write && !busy)
        begin
            unique case (avs_address)
                ADDR_CONTROL:
                begin
                    next_control[CTL_TARGET] = avs_writedata[CTL_TARGET];
                    if (eeprom_enable_pin && (avs_writedata[CTL_FETCH] || avs_writedata[CTL_COMMIT]))
                    begin
                        next_busy = 1'b1;
                        next_writing = !avs_writedata[CTL_FETCH];
                        next_wen_done = 1'b0;
                        next_step = avs_writedata[CTL_TARGET] ? 3'h0 : (avs_writedata[CTL_FETCH] ? 3'h0 : 3'h3);
                        next_state = S_PICK;
                    end
                end
                ADDR_CONFIG: next_cfg = avs_writedata[15:0];
                ADDR_BASE: next_base = avs_writedata[15:0];
                ADDR_STATION0: next_station[0] = avs_writedata[15:0];
                ADDR_STATION1: next_station[1] = avs_writedata[15:0];
                ADDR_STATION2: next_station[2] = avs_writedata[15:0];
                ADDR_POINTER: next_pointer = avs_writedata[5:0];
                ADDR_GENERAL: next_gp = avs_writedata[15:0];
                default: next_gp = gp;
            endcase
        end
        unique case (state)
            S_IDLE:
            begin
                if (!started && eeprom_enable_pin) // [RULE1] [RULE13]
                begin
                    next_busy = 1'b1;
                    next_writing = 1'b0;
                    next_step = 3'h0;
                    next_state = S_PICK;
                end
            end
            S_PICK:
            begin
                if (tick)
                begin
                    next_cs = 1'b1; // [RULE15]
                    next_sk = 1'b0;
                    next_bitcnt = 6'h00;
                    next_rxd = 16'h0000;
                    if (writing && !wen_done)
                    begin
                        next_shreg = {1'b1, OP_EXT, ADDR_WRITE_ENABLE, 16'h0000, 2'b00};
                        next_fbits = HEAD_BITS;
                    end
                    else
                    begin
                        next_shreg = {1'b1, writing ? OP_WRITE : OP_READ, cur_addr, cur_data, 2'b00}; // [RULE5]
                        next_fbits = 6'(FRAME_BITS - 6'h02);
                    end
                    // start bit goes out now so di is settled before the first sk rise
                    next_di = next_shreg[26];
                    next_shreg = {next_shreg[25:0], 1'b0};
                    next_state = S_SHIFT;
                end
            end
            S_SHIFT:
            begin
                if (tick)
                begin
                    next_sk = !sk;
                    if (sk)
                    begin
                        // di changes only on the falling half, never with the rise
                        next_di = shreg[26];
                        next_shreg = {shreg[25:0], 1'b0};
                        next_bitcnt = bitcnt + 6'h01;
                        if (bitcnt >= HEAD_BITS)
                        begin
                            next_rxd = {rxd[14:0], ee_do};
                        end
                        if (bitcnt == fbits - 6'h01)
                        begin
                            next_state = S_GAP;
                        end
                    end
                end
            end
            S_GAP:
            begin
                if (tick)
                begin
                    next_cs = 1'b0;
                    next_di = 1'b0;
                    next_poll = 32'h0;
                    next_state = (writing && wen_done) ? S_POLL : S_DONE;
                end
            end
            S_POLL:
            begin
                next_cs = 1'b1;
                next_poll = poll + 32'h1;
                if ((tick && ee_do) || poll == 32'(POLL_LIMIT_CYC))
                begin
                    next_cs = 1'b0;
                    next_state = S_DONE;
                end
            end
            S_DONE:
            begin
                if (writing && !wen_done)
                begin
                    next_wen_done = 1'b1;
                    next_state = S_PICK;
                end
                else
                begin
                    if (!writing)
                    begin
                        if (control[CTL_TARGET])
                        begin
                            next_gp = rxd;
                        end
                        else if (step == 3'h3)
                        begin
                            next_cfg = rxd; // [RULE6]
                        end
                        else if (step == 3'h4)
                        begin
                            next_base = rxd;
                        end
                        else
                        begin
                            next_station[step[1:0]] = rxd; // [RULE3]
                        end
                    end
                    if (step == last_step)
                    begin
                        next_busy = 1'b0;
                        next_state = S_IDLE;
                        if (!writing && !control[CTL_TARGET] && board_select_straps == STRAP_ALL_HIGH)
                        begin
                            next_cfg = CONFIG_DEFAULT; // [RULE4] [RULE14]
                            next_base = BASE_DEFAULT;
                        end
                    end
                    else
                    begin
                        next_step = step + 3'h1; // [RULE7]
                        next_wen_done = 1'b0;
                        next_state = S_PICK;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            state <= S_IDLE;
            control <= 3'h0; // [RULE8]
            cfg <= CONFIG_RESET;
            base <= BASE_RESET;
            gp <= 16'h0000;
            station <= '{STATION_RESET, STATION_RESET, STATION_RESET};
            pointer <= 6'h00;
            busy <= 1'b0;
            step <= 3'h0;
            writing <= 1'b0;
            wen_done <= 1'b0;
            shreg <= 27'h0;
            bitcnt <= 6'h00;
            fbits <= 6'h00;
            rxd <= 16'h0000;
            div <= 8'h00;
            sk <= 1'b0;
            cs <= 1'b0;
            di <= 1'b0;
            poll <= 32'h0;
            started <= 1'b0;
        end
        else
        begin
            state <= next_state;
            control <= next_control;
            cfg <= next_cfg;
            base <= next_base;
            gp <= next_gp;
            station <= next_station;
            pointer <= next_pointer;
            busy <= next_busy;
            step <= next_step;
            writing <= next_writing;
            wen_done <= next_wen_done;
            shreg <= next_shreg;
            bitcnt <= next_bitcnt;
            fbits <= next_fbits;
            rxd <= next_rxd;
            div <= next_div;
            sk <= next_sk;
            cs <= next_cs;
            di <= next_di;
            poll <= next_poll;
            started <= next_started;
        end
    end

    assign ee_cs = cs;
    assign ee_sk = sk;
    assign ee_di = di;
    assign config_word = cfg;
    assign base_word = base;

    property p_stall;
        @(posedge clk_sys) disable iff (sys_rst) (busy && avs_write) |-> avs_waitrequest;
    endproperty
    a_stall: assert property (p_stall) else $error("access not stalled while busy"); // [RULE12]

    property p_trig;
        @(posedge clk_sys) disable iff (sys_rst)
            (busy && avs_address == ADDR_CONTROL) |-> avs_readdata[1:0] == 2'b11;
    endproperty
    a_trig: assert property (p_trig) else $error("triggers low during access"); // [RULE11]

    property p_noee;
        @(posedge clk_sys) disable iff (sys_rst) !eeprom_enable_pin && !busy |=> !ee_cs;
    endproperty
    a_noee: assert property (p_noee) else $error("eeprom selected while disabled"); // [RULE13]

    property p_auto;
        @(posedge clk_sys) disable iff (sys_rst) (!started && eeprom_enable_pin) |=> busy;
    endproperty
    a_auto: assert property (p_auto) else $error("no fetch after reset"); // [RULE1]

    property p_def;
        @(posedge clk_sys) disable iff (sys_rst)
            (state == S_DONE && step == 3'h2 && !writing && !control[CTL_TARGET]
             && board_select_straps == STRAP_ALL_HIGH) |=> base == BASE_DEFAULT;
    endproperty
    a_def: assert property (p_def) else $error("default base not applied"); // [RULE4]

    property p_addr;
        @(posedge clk_sys) disable iff (sys_rst)
            (state == S_PICK && step == 3'h3 && !control[CTL_TARGET]) |-> cur_addr == strap_word;
    endproperty
    a_addr: assert property (p_addr) else $error("config word address wrong"); // [RULE2]

    property p_sta;
        @(posedge clk_sys) disable iff (sys_rst)
            (state == S_PICK && step <= 3'h2 && !control[CTL_TARGET]) |-> cur_addr[5];
    endproperty
    a_sta: assert property (p_sta) else $error("station address outside area"); // [RULE3]

    property p_ptr;
        @(posedge clk_sys) disable iff (sys_rst)
            (state == S_PICK && control[CTL_TARGET]) |-> cur_addr == pointer;
    endproperty
    a_ptr: assert property (p_ptr) else $error("general access not at pointer"); // [RULE9]
endmodule : serial_eeprom_board_setup_loader

// ---- setup_loader_pkg.sv ----
// constants for the board setup loader
package setup_loader_pkg;
    localparam int CLK_HZ = 40000000;
    localparam int SK_HZ_MAX = 1000000;
    localparam int SK_HALF_CYC = CLK_HZ / (2 * SK_HZ_MAX);
    localparam int POLL_LIMIT_MS = 10;
    localparam int POLL_LIMIT_CYC = (CLK_HZ / 1000) * POLL_LIMIT_MS;
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_CONFIG = 4'h1;
    localparam logic [3:0] ADDR_BASE = 4'h2;
    localparam logic [3:0] ADDR_STATION0 = 4'h3;
    localparam logic [3:0] ADDR_STATION1 = 4'h4;
    localparam logic [3:0] ADDR_STATION2 = 4'h5;
    localparam logic [3:0] ADDR_POINTER = 4'h6;
    localparam logic [3:0] ADDR_GENERAL = 4'h7;
    localparam int CTL_TARGET = 2;
    localparam int CTL_FETCH = 1;
    localparam int CTL_COMMIT = 0;
    localparam logic [15:0] CONFIG_RESET = 16'h0000;
    localparam logic [15:0] BASE_RESET = 16'h0000;
    localparam logic [15:0] CONFIG_DEFAULT = 16'h0000;
    localparam logic [15:0] BASE_DEFAULT = 16'h1801;
    localparam logic [15:0] STATION_RESET = 16'h0000;
    localparam logic [2:0] STRAP_ALL_HIGH = 3'h7;
    localparam logic [5:0] STATION_WORD0 = 6'h20;
    localparam logic [5:0] WORD_STRIDE_SHIFT = 6'h2;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_EXT = 2'h0;
    localparam logic [5:0] ADDR_WRITE_ENABLE = 6'h30;
    localparam logic [5:0] FRAME_BITS = 6'h1B;
    localparam logic [5:0] HEAD_BITS = 6'h09;
endpackage : setup_loader_pkg

// ---- serial_eeprom_model.sv ----
// behavioural three-wire serial eeprom, 64 words of 16 bits
`timescale 1ns/100ps
module serial_eeprom_model
    import setup_loader_pkg::*;
#(
    parameter int BUSY_NS = 4000
)
(
    input wire logic cs, // chip select
    input wire logic sk, // serial clock
    input wire logic din, // data into the eeprom
    output logic dout // data out of the eeprom
);
    logic [15:0] mem [64];
    logic [15:0] shin;
    logic [15:0] shout;
    logic [7:0] head;
    logic wen = 1'b0;
    logic busy = 1'b0;
    int cnt = 0;
    initial dout = 1'b1;
    always @(posedge sk)
    begin
        if (cs && !busy)
        begin
            if (cnt == 0)
                cnt = din ? 1 : 0;
            else
            begin
                cnt = cnt + 1;
                if (cnt <= 9)
                    head = {head[6:0], din};
                else if (head[7:6] == OP_READ)
                begin
                    dout <= shout[15];
                    shout = shout << 1;
                end
                else
                    shin = {shin[14:0], din};
                if (cnt == 9 && head[7:6] == OP_READ)
                begin
                    dout <= 1'b0;
                    shout = mem[head[5:0]];
                end
            end
        end
    end
    always @(negedge cs)
    begin
        // a released line must not keep showing the last bit
        dout <= ~dout;
        if (head[7:6] == OP_EXT && cnt >= 9)
            wen = (head[5:4] == ADDR_WRITE_ENABLE[5:4]);
        else if (head[7:6] == OP_WRITE && cnt >= 25 && wen)
        begin
            mem[head[5:0]] = shin;
            busy = 1'b1;
            busy <= #(BUSY_NS) 1'b0;
        end
        cnt = 0;
    end
    always @(posedge cs or negedge busy)
        if (cs)
            dout <= ~busy;
endmodule : serial_eeprom_model

// ---- test_serial_eeprom_board_setup_loader.sv ----
// self-checking bench for the board setup loader
`timescale 1ns/100ps
module test_serial_eeprom_board_setup_loader;
    import setup_loader_pkg::*;
    typedef struct {logic [3:0] adr; logic [31:0] wd; logic [15:0] exp;} row_s;
    logic clk_sys, sys_rst, avs_read, avs_write, avs_waitrequest, eeprom_enable_pin;
    logic ee_cs, ee_sk, ee_di, ee_do;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [2:0] board_select_straps;
    logic [15:0] config_word, base_word;
    int err_count = 0;
    int compares = 0;
    int waits, f0;
    int frames = 0;
    row_s rows [9] = '{'{ADDR_CONFIG, 32'hFFFF1234, 16'h1234},
        '{ADDR_BASE, 32'h0000ABCD, 16'hABCD}, '{ADDR_STATION0, 32'h1111, 16'h1111},
        '{ADDR_STATION1, 32'h2222, 16'h2222}, '{ADDR_STATION2, 32'h3333, 16'h3333},
        '{ADDR_POINTER, 32'hFFFF, 16'h003F}, '{ADDR_GENERAL, 32'h5A5A, 16'h5A5A},
        '{ADDR_CONTROL, 32'h4, 16'h0004}, '{4'hB, 32'hFFFF, 16'h0000}};
    serial_eeprom_board_setup_loader serial_eeprom_board_setup_loader_i (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .board_select_straps(board_select_straps),
        .eeprom_enable_pin(eeprom_enable_pin), .ee_cs(ee_cs), .ee_sk(ee_sk), .ee_di(ee_di),
        .ee_do(ee_do), .config_word(config_word), .base_word(base_word));
    serial_eeprom_model serial_eeprom_model_i (.cs(ee_cs), .sk(ee_sk), .din(ee_di),
        .dout(ee_do));
    always @(posedge ee_cs) frames++;
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    function logic [15:0] pat(input int i);
        return 16'hA500 | i[15:0];
    endfunction : pat
    task check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task end_of_test;
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    // waitrequest and readdata are read at the edge, before that edge's updates land
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 40000);
        rd = avs_readdata;
        waits = n;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 40000)
        begin
            err_count++;
            $display("[FAIL] waitrequest expected 0 seen 1");
            end_of_test();
        end
    endtask : bus
    task rdchk(input string what, input logic [3:0] a, input logic [15:0] exp);
        bus(1'b0, a, 32'h0);
        check(what, exp, rd[15:0]);
    endtask : rdchk
    task do_reset(input logic [2:0] s, input logic en);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        board_select_straps <= s;
        eeprom_enable_pin <= en;
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        f0 = frames;
    endtask : do_reset
    initial
    begin
        sys_rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        board_select_straps = 3'h0;
        eeprom_enable_pin = 1'b0;
        for (int i = 0; i < 64; i++)
            serial_eeprom_model_i.mem[i] = pat(i);
        do_reset(3'h0, 1'b0);
        rdchk("config", ADDR_CONFIG, CONFIG_RESET);
        check("first wait", 16'h0001, 16'(waits));
        rdchk("station0", ADDR_STATION0, STATION_RESET);
        foreach (rows[i])
        begin
            bus(1'b1, rows[i].adr, rows[i].wd);
            rdchk("register", rows[i].adr, rows[i].exp);
        end
        check("frames", 16'h0000, 16'(frames));
        $display("test no_eeprom done");
        do_reset(3'h3, 1'b1);
        rdchk("config", ADDR_CONFIG, pat(12));
        check("stalled", 16'h0001, {15'h0, waits > 1000});
        rdchk("base", ADDR_BASE, pat(13));
        for (int i = 0; i < 3; i++)
            rdchk("station", ADDR_STATION0 + 4'(i), pat(32 + i));
        check("config_word", pat(12), config_word);
        check("base_word", pat(13), base_word);
        rdchk("control", ADDR_CONTROL, 16'h0000);
        check("frames", 16'h0005, 16'(frames - f0));
        $display("test auto_fetch done");
        do_reset(3'h7, 1'b1);
        rdchk("config", ADDR_CONFIG, CONFIG_DEFAULT);
        rdchk("base", ADDR_BASE, BASE_DEFAULT);
        rdchk("station2", ADDR_STATION2, pat(34));
        check("frames", 16'h0003, 16'(frames - f0));
        $display("test straps_high done");
        do_reset(3'h5, 1'b1);
        bus(1'b1, ADDR_POINTER, 32'hFFEB);
        bus(1'b1, ADDR_CONTROL, 32'h6);
        rdchk("control", ADDR_CONTROL, 16'h0004);
        rdchk("general", ADDR_GENERAL, pat(43));
        bus(1'b1, ADDR_GENERAL, 32'h1357);
        bus(1'b1, ADDR_CONTROL, 32'h5);
        rdchk("control", ADDR_CONTROL, 16'h0004);
        check("word 2B", 16'h1357, serial_eeprom_model_i.mem[43]);
        $display("test general_path done");
        bus(1'b1, ADDR_CONTROL, 32'h0);
        bus(1'b1, ADDR_CONFIG, 32'h2468);
        bus(1'b1, ADDR_BASE, 32'h369C);
        bus(1'b1, ADDR_CONTROL, 32'h1);
        rdchk("control", ADDR_CONTROL, 16'h0000);
        check("word 14", 16'h2468, serial_eeprom_model_i.mem[20]);
        check("word 15", 16'h369C, serial_eeprom_model_i.mem[21]);
        check("word 16", pat(22), serial_eeprom_model_i.mem[22]);
        serial_eeprom_model_i.mem[20] = 16'h1111;
        serial_eeprom_model_i.mem[32] = 16'h7777;
        bus(1'b1, ADDR_CONTROL, 32'h2);
        rdchk("config", ADDR_CONFIG, 16'h1111);
        rdchk("station0", ADDR_STATION0, 16'h7777);
        $display("test store_reload done");
        end_of_test();
    end
endmodule : test_serial_eeprom_board_setup_loader
